// file: design/mtc_pkg.sv
// shared constants, field layout and carrier types of the memory table copy command block
package mtc_pkg;

  // ***********************************************************
  // clock and polling
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 8;
  // interval between two samples of the command words (least time)
  localparam int POLL_TIME_NS = 1000;
  localparam int POLL_CYCLES = (POLL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_CNT_W = 8;
  localparam logic [POLL_CNT_W-1:0] POLL_LAST = POLL_CNT_W'(POLL_CYCLES - 1);

  // ***********************************************************
  // command word offsets from the status control area base
  // ***********************************************************
  localparam logic [15:0] SRC_WORD_OFS = 16'h0001;
  localparam logic [15:0] DST_WORD_OFS = 16'h0002;

  // ***********************************************************
  // field layout of the command words
  // ***********************************************************
  localparam int WORD_W = 16;
  localparam int BCD_W = 12;
  localparam int BCD_LSB = 0;
  localparam int TOP_LSB = 12;
  localparam int TOP_W = 4;
  localparam int ENTRY_NUM_W = 7;
  localparam int ENTRY_W = 128;
  localparam logic [TOP_W-1:0] TYPE_CHAR = 4'h0;
  localparam logic [TOP_W-1:0] TYPE_NUM = 4'h1;
  localparam logic [TOP_W-1:0] SRC_TOP_ZERO = 4'h0;
  localparam logic [9:0] ENTRY_MAX = 10'h07F;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [WORD_W-1:0] CMD_WORD_RST = 16'h0000;
  localparam logic [ENTRY_W-1:0] ENTRY_RST = 128'h0;

  // table selector values
  localparam logic TBL_CHAR = 1'b0;
  localparam logic TBL_NUM = 1'b1;

  // ***********************************************************
  // carrier types
  // ***********************************************************
  typedef struct packed {
    logic [WORD_W-1:0] dst_word;
    logic [WORD_W-1:0] src_word;
  } mtc_cmd_s;

  typedef struct packed {
    logic sel;
    logic [ENTRY_NUM_W-1:0] entry;
  } mtc_ref_s;

endpackage : mtc_pkg

// file: design/mtc_bcd_entry.sv
// three-digit bcd entry number decoder with range check
`timescale 1ns/1ps

module mtc_bcd_entry (
  // bcd digits in
  input wire logic [mtc_pkg::BCD_W-1:0] bcd,
  // decoded entry
  output logic [mtc_pkg::ENTRY_NUM_W-1:0] value,
  output logic ok
);

  // ***********************************************************
  // digit checks
  // ***********************************************************
  function automatic logic is_digit(input logic [3:0] nib);
    is_digit = (nib <= mtc_pkg::BCD_DIGIT_MAX);
  endfunction : is_digit

  logic [2:0] digit_ok;
  logic [9:0] full;

  // one check per digit; a hex digit rejects the whole number
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_digit
      assign digit_ok[gi] = is_digit(bcd[gi*4 +: 4]);
    end
  endgenerate

  // binary value, widest case 999 fits ten bits
  assign full = 10'(bcd[11:8]) * 10'd100 + 10'(bcd[7:4]) * 10'd10 + 10'(bcd[3:0]);
  assign ok = (&digit_ok) && (full <= mtc_pkg::ENTRY_MAX);
  assign value = full[mtc_pkg::ENTRY_NUM_W-1:0];

endmodule : mtc_bcd_entry

// file: design/mtc_copy_cmd.sv
// memory table copy command interpreter of the operator terminal
`timescale 1ns/1ps

module mtc_copy_cmd (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // location of the status control area in controller memory
  input wire logic [15:0] area_base,
  // read port into the logic controller data memory area
  output logic mem_rd_req,
  output logic [15:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [mtc_pkg::WORD_W-1:0] mem_rd_data,
  // memory table read port
  output logic tbl_rd_req,
  output mtc_pkg::mtc_ref_s tbl_rd_ref,
  input wire logic tbl_rd_ack,
  input wire logic [mtc_pkg::ENTRY_W-1:0] tbl_rd_data,
  // memory table write port
  output logic tbl_wr_en,
  output mtc_pkg::mtc_ref_s tbl_wr_ref,
  output logic [mtc_pkg::ENTRY_W-1:0] tbl_wr_data,
  // display refresh request
  output logic disp_refresh,
  output mtc_pkg::mtc_ref_s disp_ref,
  // status
  output logic busy,
  output logic reject,
  output mtc_pkg::mtc_cmd_s last_cmd
);

  // ***********************************************************
  // state and storage
  // ***********************************************************
  typedef enum logic [2:0] {
    ST_WAIT,
    ST_RD_SRC,
    ST_RD_DST,
    ST_CHECK,
    ST_TBL_RD,
    ST_TBL_WR,
    ST_REFRESH
  } mtc_state_e;

  mtc_state_e state;
  mtc_state_e next_state;
  logic [mtc_pkg::POLL_CNT_W-1:0] poll_cnt;
  mtc_pkg::mtc_cmd_s cur_cmd;
  mtc_pkg::mtc_cmd_s prev_cmd;
  logic armed;
  logic [mtc_pkg::ENTRY_W-1:0] copy_data;
  logic rejected;

  // ***********************************************************
  // field decode of the sampled words
  // ***********************************************************
  logic [mtc_pkg::TOP_W-1:0] copy_type;
  logic [mtc_pkg::TOP_W-1:0] src_top;
  logic [mtc_pkg::ENTRY_NUM_W-1:0] src_entry;
  logic [mtc_pkg::ENTRY_NUM_W-1:0] dst_entry;
  logic src_ok;
  logic dst_ok;
  logic type_ok;
  logic changed;
  logic go_copy;
  logic poll_due;

  // type in top nibble of the second word, source top nibble must be zero
  assign copy_type = cur_cmd.dst_word[mtc_pkg::TOP_LSB +: mtc_pkg::TOP_W];
  assign src_top = cur_cmd.src_word[mtc_pkg::TOP_LSB +: mtc_pkg::TOP_W];

  mtc_bcd_entry u_src_bcd (
    .bcd(cur_cmd.src_word[mtc_pkg::BCD_LSB +: mtc_pkg::BCD_W]),
    .value(src_entry),
    .ok(src_ok)
  );

  mtc_bcd_entry u_dst_bcd (
    .bcd(cur_cmd.dst_word[mtc_pkg::BCD_LSB +: mtc_pkg::BCD_W]),
    .value(dst_entry),
    .ok(dst_ok)
  );

  // only the two documented types start a copy
  assign type_ok = (copy_type == mtc_pkg::TYPE_CHAR) || (copy_type == mtc_pkg::TYPE_NUM);
  // both words compared; first pass after reset only arms the detector
  assign changed = armed && (cur_cmd != prev_cmd);
  assign go_copy = changed && type_ok && src_ok && dst_ok && (src_top == mtc_pkg::SRC_TOP_ZERO);
  assign poll_due = (poll_cnt == mtc_pkg::POLL_LAST);

  // ***********************************************************
  // handshake outputs
  // ***********************************************************
  assign mem_rd_req = (state == ST_RD_SRC) || (state == ST_RD_DST);
  assign tbl_rd_req = (state == ST_TBL_RD);
  assign tbl_wr_en = (state == ST_TBL_WR);
  assign disp_refresh = (state == ST_REFRESH);
  assign busy = (state != ST_WAIT);
  assign reject = rejected;
  assign last_cmd = cur_cmd;

  // ***********************************************************
  // sequencing
  // ***********************************************************
  // words are read one at a time with no lock, so a half-written pair may be seen
  always_comb begin
    next_state = state;
    unique case (state)
      ST_WAIT: begin
        if (poll_due) begin
          next_state = ST_RD_SRC;
        end
      end
      ST_RD_SRC: begin
        if (mem_rd_ack) begin
          next_state = ST_RD_DST;
        end
      end
      ST_RD_DST: begin
        if (mem_rd_ack) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        next_state = go_copy ? ST_TBL_RD : ST_WAIT;
      end
      ST_TBL_RD: begin
        if (tbl_rd_ack) begin
          next_state = ST_TBL_WR;
        end
      end
      ST_TBL_WR: begin
        next_state = ST_REFRESH;
      end
      ST_REFRESH: begin
        next_state = ST_WAIT;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // poll interval timer, runs only while idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      poll_cnt <= '0;
    end else if (state != ST_WAIT || poll_due) begin
      poll_cnt <= '0;
    end else begin
      poll_cnt <= poll_cnt + 1'b1;
    end
  end

  // controller address: only the two command words are ever fetched here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_rd_addr <= 16'h0000;
    end else if (state == ST_WAIT && poll_due) begin
      mem_rd_addr <= area_base + mtc_pkg::SRC_WORD_OFS;
    end else if (state == ST_RD_SRC && mem_rd_ack) begin
      mem_rd_addr <= area_base + mtc_pkg::DST_WORD_OFS;
    end
  end

  // capture of the sampled words
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_cmd <= {mtc_pkg::CMD_WORD_RST, mtc_pkg::CMD_WORD_RST};
    end else if (state == ST_RD_SRC && mem_rd_ack) begin
      cur_cmd.src_word <= mem_rd_data;
    end else if (state == ST_RD_DST && mem_rd_ack) begin
      cur_cmd.dst_word <= mem_rd_data;
    end
  end

  // previous sample for change detection; an invalid type is also remembered
  // so that rewriting a valid type afterwards counts as a change
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_cmd <= {mtc_pkg::CMD_WORD_RST, mtc_pkg::CMD_WORD_RST};
      armed <= 1'b0;
    end else if (state == ST_CHECK) begin
      prev_cmd <= cur_cmd;
      armed <= 1'b1;
    end
  end

  // rejected pulse: words changed but did not form a legal command
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rejected <= 1'b0;
    end else begin
      rejected <= (state == ST_CHECK) && changed && !go_copy;
    end
  end

  // table references: held until the next copy is accepted
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tbl_rd_ref <= '0;
      tbl_wr_ref <= '0;
    end else if (state == ST_CHECK && go_copy) begin
      tbl_rd_ref <= {copy_type == mtc_pkg::TYPE_NUM, src_entry};
      tbl_wr_ref <= {copy_type == mtc_pkg::TYPE_NUM, dst_entry};
    end
  end

  // source entry comes from the terminal's own table, never refetched
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      copy_data <= mtc_pkg::ENTRY_RST;
    end else if (state == ST_TBL_RD && tbl_rd_ack) begin
      copy_data <= tbl_rd_data;
    end
  end
  assign tbl_wr_data = copy_data;

  // refresh target follows the destination just written
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      disp_ref <= '0;
    end else if (state == ST_TBL_WR) begin
      disp_ref <= tbl_wr_ref;
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_src_taken;
    (state == ST_RD_SRC) && mem_rd_ack;
  endsequence

  sequence s_dst_asked;
    mem_rd_req && (mem_rd_addr == area_base + mtc_pkg::DST_WORD_OFS);
  endsequence

  chk_char_copy_type: assert property (
    (tbl_wr_en && tbl_wr_ref.sel == mtc_pkg::TBL_CHAR) |-> (copy_type == mtc_pkg::TYPE_CHAR))
    else $error("char table written without type zero");

  chk_num_copy_type: assert property (
    (tbl_wr_en && tbl_wr_ref.sel == mtc_pkg::TBL_NUM) |-> (copy_type == mtc_pkg::TYPE_NUM))
    else $error("numeral table written without type one");

  chk_entry_in_range: assert property (
    tbl_rd_req |-> (src_ok && dst_ok && (tbl_rd_ref.entry == src_entry) && (tbl_wr_ref.entry == dst_entry)))
    else $error("copy started with out of range entry");

  chk_bad_type_idle: assert property (
    ((state == ST_CHECK) && !type_ok) |=> (state == ST_WAIT) ##1 !tbl_wr_en)
    else $error("copy proceeded with invalid type");

  chk_unchanged_idle: assert property (
    ((state == ST_CHECK) && (cur_cmd == prev_cmd)) |=> !tbl_rd_req [*3])
    else $error("copy repeated on unchanged words");

  chk_word_order: assert property (
    s_src_taken |=> s_dst_asked)
    else $error("second word not read right after first");

  chk_refresh_dest: assert property (
    tbl_wr_en |=> disp_refresh && (disp_ref == $past(tbl_wr_ref)))
    else $error("display refresh missing or wrong entry");

  chk_no_src_fetch: assert property (
    mem_rd_req |-> ((mem_rd_addr == area_base + mtc_pkg::SRC_WORD_OFS) ||
                    (mem_rd_addr == area_base + mtc_pkg::DST_WORD_OFS)))
    else $error("controller read outside the command words");

  chk_copy_data: assert property (
    (tbl_rd_req && tbl_rd_ack) |=> tbl_wr_en && (tbl_wr_data == $past(tbl_rd_data)))
    else $error("written entry differs from table read");

  chk_hex_reject: assert property (
    ((state == ST_CHECK) && changed && type_ok && !src_ok) |=> reject && (state == ST_WAIT))
    else $error("non-bcd source not rejected");

endmodule : mtc_copy_cmd

// file: verification/mtc_plc_model.sv
// controller memory model holding the two copy command words
`timescale 1ns/1ps

module mtc_plc_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // word read port from the terminal
  input wire logic [15:0] area_base,
  input wire logic mem_rd_req,
  input wire logic [15:0] mem_rd_addr,
  output logic mem_rd_ack,
  output logic [15:0] mem_rd_data,
  // command words and answer delay set by the bench
  input wire logic [15:0] src_word,
  input wire logic [15:0] dst_word,
  input wire logic [3:0] lag
);
  logic [3:0] wait_cnt;
  logic [15:0] word_sel;

  // word lookup; unmapped addresses return a marker value
  assign word_sel = (mem_rd_addr == area_base + 16'h0001) ? src_word :
                    (mem_rd_addr == area_base + 16'h0002) ? dst_word : 16'hDEAD;

  // one-cycle ack after lag cycles; released data shows the inverse so stale reads show up
  always @(negedge mclk or posedge rst) begin
    if (rst) begin
      mem_rd_ack <= 1'b0;
      mem_rd_data <= 16'h0000;
      wait_cnt <= 4'h0;
    end else if (mem_rd_req && !mem_rd_ack && wait_cnt >= lag) begin
      mem_rd_ack <= 1'b1;
      mem_rd_data <= word_sel;
      wait_cnt <= 4'h0;
    end else begin
      mem_rd_ack <= 1'b0;
      mem_rd_data <= ~mem_rd_data;
      wait_cnt <= mem_rd_req ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : mtc_plc_model

// file: verification/test_mtc_copy_cmd.sv
// self-checking bench of the memory table copy command interpreter
`timescale 1ns/1ps

module test_mtc_copy_cmd;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] area_base = 16'h0100;
  logic mem_rd_req, mem_rd_ack, tbl_rd_req, tbl_wr_en, disp_refresh, busy, reject;
  logic [15:0] mem_rd_addr, mem_rd_data;
  logic [15:0] src_w = 16'h0000;
  logic [15:0] dst_w = 16'hF000;
  logic [3:0] lag = 4'h0;
  logic tbl_rd_ack = 1'b0;
  logic [127:0] tbl_rd_data = 128'h0;
  logic [127:0] tbl_wr_data, wdata;
  mtc_pkg::mtc_ref_s tbl_rd_ref, tbl_wr_ref, disp_ref, wref, dref;
  mtc_pkg::mtc_cmd_s last_cmd;
  int err_total = 0;
  int check_count = 0;
  int wr_cnt, rej_cnt, rd_cnt, disp_cnt;

  always #4 mclk = ~mclk;

  mtc_copy_cmd u_dut (.mclk(mclk), .rst(rst), .area_base(area_base), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
    .tbl_rd_req(tbl_rd_req), .tbl_rd_ref(tbl_rd_ref), .tbl_rd_ack(tbl_rd_ack),
    .tbl_rd_data(tbl_rd_data), .tbl_wr_en(tbl_wr_en), .tbl_wr_ref(tbl_wr_ref),
    .tbl_wr_data(tbl_wr_data), .disp_refresh(disp_refresh), .disp_ref(disp_ref), .busy(busy),
    .reject(reject), .last_cmd(last_cmd));

  mtc_plc_model u_plc (.mclk(mclk), .rst(rst), .area_base(area_base), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
    .src_word(src_w), .dst_word(dst_w), .lag(lag));

  // ***********************************************************
  // table side: entry content is the reference repeated
  // ***********************************************************
  always @(negedge mclk) begin
    tbl_rd_ack <= tbl_rd_req && !tbl_rd_ack;
    tbl_rd_data <= (tbl_rd_req && !tbl_rd_ack) ? {16{tbl_rd_ref}} : ~tbl_rd_data;
  end

  // event monitor, sampled on the design's clock edge
  always @(posedge mclk) begin
    if (tbl_wr_en === 1'b1) begin
      wr_cnt++;
      wref = tbl_wr_ref;
      wdata = tbl_wr_data;
    end
    if (disp_refresh === 1'b1) begin
      disp_cnt++;
      dref = disp_ref;
    end
    if (reject === 1'b1) rej_cnt++;
    if (mem_rd_req === 1'b1 && mem_rd_ack === 1'b1) rd_cnt++;
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // write both words in the idle gap, then judge the next poll
  task automatic run_poll(input logic [15:0] s, input logic [15:0] d, input logic [3:0] lg,
                          input int n_wr, input int n_rej, input logic [7:0] er, input logic [7:0] es);
    int i;
    @(negedge mclk);
    dst_w = d;
    @(negedge mclk);
    src_w = s;
    lag = lg;
    wr_cnt = 0;
    rej_cnt = 0;
    rd_cnt = 0;
    disp_cnt = 0;
    for (i = 0; i < 300 && mem_rd_req !== 1'b1; i++) @(negedge mclk);
    chk(mem_rd_req, 1'b1);
    for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge mclk);
    chk(busy, 1'b0);
    repeat (2) @(negedge mclk);
    chk(wr_cnt, n_wr);
    chk(rej_cnt, n_rej);
    chk(rd_cnt, 2);
    chk(disp_cnt, n_wr);
    chk(last_cmd, {d, s});
    if (n_wr > 0) begin
      chk(wref, er);
      chk(wdata, {16{es}});
      chk(dref, er);
    end
  endtask : run_poll

  task automatic complete_run;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // watchdog, well beyond the roughly 3400 cycles of the tests
  initial begin
    #200000;
    err_total++;
    complete_run();
  end

  initial begin
    int t;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    run_poll(16'h0000, 16'hF000, 4'h0, 0, 0, 8'h00, 8'h00); // first sample only arms
    run_poll(16'h0005, 16'h0012, 4'h0, 1, 0, 8'h0C, 8'h05);
    run_poll(16'h0005, 16'h0012, 4'h3, 0, 0, 8'h00, 8'h00); // unchanged words
    run_poll(16'h0127, 16'h1000, 4'h3, 1, 0, 8'h80, 8'hFF); // range ends
    run_poll(16'h0127, 16'h2000, 4'h0, 0, 1, 8'h00, 8'h00);
    run_poll(16'h0127, 16'h1000, 4'h0, 1, 0, 8'h80, 8'hFF); // repeat after invalid
    run_poll(16'h0128, 16'h1000, 4'h0, 0, 1, 8'h00, 8'h00);
    run_poll(16'h000A, 16'h1000, 4'h0, 0, 1, 8'h00, 8'h00);
    run_poll(16'h1005, 16'h1000, 4'h0, 0, 1, 8'h00, 8'h00);
    // every other copy type is refused
    for (t = 2; t < 16; t++) begin
      run_poll(16'h0005, {t[3:0], 12'h012}, 4'h1, 0, 1, 8'h00, 8'h00);
    end
    run_poll(16'h0005, 16'h0128, 4'h2, 0, 1, 8'h00, 8'h00); // destination out of range
    // a reset in mid-run disarms the detector, so its first sample copies nothing
    @(negedge mclk);
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    run_poll(16'h0005, 16'h1012, 4'h0, 0, 0, 8'h00, 8'h00);
    run_poll(16'h0005, 16'h0012, 4'h0, 1, 0, 8'h0C, 8'h05);
    complete_run();
  end
endmodule : test_mtc_copy_cmd
